// [usb_link_cfg_pkg.sv]
// Constants, field layout and carrier types of the USB link configuration register bank
package usb_link_cfg_pkg;

  // Register byte offsets
  localparam logic [11:0] CFG0_OFF = 12'h080;
  localparam logic [11:0] STATUS_OFF = 12'h084;
  localparam logic [11:0] PROTECT_OFF = 12'h088;

  // Field positions inside usb_link_config0
  localparam int RSVD_BIT = 31;
  localparam int LINK_POWER_MGMT_CAPABILITY_BIT = 30;
  localparam int SUSP_BIT = 29;
  localparam int THR_LSB = 24;
  localparam int BIN_LSB = 20;
  localparam int BOUT_LSB = 16;
  localparam int SPD_LSB = 13;
  localparam int OVL_BIT = 12;
  localparam int CFG_LSB = 12;
  localparam int CFG_MSB = 30;

  // Connect speed encodings
  localparam logic [2:0] SPD_SUPER = 3'h4;
  localparam logic [2:0] SPD_HIGH = 3'h0;
  localparam logic [2:0] SPD_FULL = 3'h1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Resume signalling time: base plus one step per code increment
  localparam int CLK_MHZ = 20;
  localparam int RESUME_BASE_US = 50;
  localparam int RESUME_STEP_US = 75;
  localparam int RESUME_BASE_CYC = RESUME_BASE_US * CLK_MHZ;
  localparam int RESUME_STEP_CYC = RESUME_STEP_US * CLK_MHZ;
  localparam int RESUME_CNT_W = 16;

  // Configuration fields, in the same order as bits 30:12 of the register
  typedef struct packed {
    logic link_power_mgmt_capability;
    logic suspend_allow;
    logic [4:0] resume_duration_threshold;
    logic [3:0] bulk_in_burst_limit;
    logic [3:0] bulk_out_burst_limit;
    logic [2:0] connect_speed_select;
    logic lfps_overlap_check_enable;
  } link_cfg_t;

  localparam link_cfg_t CFG_RST = '{
    link_power_mgmt_capability: 1'b0,
    suspend_allow: 1'b1,
    resume_duration_threshold: 5'h00,
    bulk_in_burst_limit: 4'h0,
    bulk_out_burst_limit: 4'h0,
    connect_speed_select: SPD_SUPER,
    lfps_overlap_check_enable: 1'b0
  };
  localparam logic PROTECT_RST = 1'b0;

  // Link-side events after synchronisation
  typedef struct packed {
    logic lpm_req;
    logic [3:0] hird;
    logic l1_exit;
    logic suspend_cond;
    logic ux_exit_start;
    logic remote_lfps;
    logic ts_seen;
  } link_in_t;

endpackage

// [resume_timer.sv]
// Times resume signalling from L1 for a duration chosen by a four-bit code
`timescale 1ns/1ps
`default_nettype none
module resume_timer #(
  parameter int BASE_CYC = usb_link_cfg_pkg::RESUME_BASE_CYC,
  parameter int STEP_CYC = usb_link_cfg_pkg::RESUME_STEP_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic start,
  input wire logic [3:0] code,
  // Status
  output logic active_q,
  output logic done_q
);
  localparam int W = usb_link_cfg_pkg::RESUME_CNT_W;
  logic [W-1:0] cnt_q;
  wire [W-1:0] limit = W'(BASE_CYC) + W'(STEP_CYC) * W'(code);
  wire last = active_q && (cnt_q == limit - W'(1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_q <= 1'b0;
      cnt_q <= '0;
      done_q <= 1'b0;
    end else begin
      done_q <= last;
      if (start && !active_q) begin
        active_q <= 1'b1;
        cnt_q <= '0;
      end else if (last) begin
        active_q <= 1'b0;
      end else if (active_q) begin
        cnt_q <= cnt_q + W'(1);
      end
    end
  end
endmodule
`default_nettype wire

// [ux_exit_handshake.sv]
// Decides when the LFPS handshake on a U1/U2/U3 exit counts as complete
`timescale 1ns/1ps
`default_nettype none
module ux_exit_handshake (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control and link events
  input wire logic check_en,
  input wire logic exit_start,
  input wire logic remote_lfps,
  input wire logic ts_seen,
  // Status
  output logic waiting_q,
  output logic done_q
);
  typedef enum logic [0:0] {IDLE, WAIT_REMOTE} hs_state_t;
  hs_state_t state_q;
  hs_state_t state_d;
  logic done_d;

  always_comb begin
    state_d = state_q;
    done_d = 1'b0;
    case (state_q)
      IDLE: begin
        if (exit_start && check_en) begin
          state_d = WAIT_REMOTE;
        end else if (exit_start) begin
          done_d = 1'b1;
        end
      end
      WAIT_REMOTE: begin
        if (remote_lfps || ts_seen) begin
          state_d = IDLE;
          done_d = 1'b1;
        end
      end
      default: state_d = IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= IDLE;
      done_q <= 1'b0;
      waiting_q <= 1'b0;
    end else begin
      state_q <= state_d;
      done_q <= done_d;
      waiting_q <= (state_d == WAIT_REMOTE);
    end
  end
endmodule
`default_nettype wire

// [usb_link_config_register.sv]
// USB link configuration register with AXI4-Lite access and the link logic it steers
// Overview of operation
// - The LPM capability bit decides whether an LPM request is accepted into L1 or refused.
// - With suspend_allow clear the PHY suspend pin never asserts; set, it follows valid suspend conditions.
// - In L1 the PHY goes to deep low-power only when host HIRD >= threshold[3:0] and threshold[4] is 1.
// - In L1 the PHY goes to UTMI sleep when host HIRD < threshold[3:0] or threshold[4] is 0.
// - The resume signalling time is 50 us at code zero plus 75 us per code step.
// - The bulk-in burst field gives the SuperSpeed bulk-in burst as packets minus one.
// - The bulk-out burst field gives the SuperSpeed bulk-out burst as packets minus one.
// - The speed field selects SuperSpeed (100), High-Speed (000) or Full-Speed (001) and resets to 100.
// - With overlap check on, a Ux exit waits for remote LFPS or TS1/TS2 before the handshake completes.
// - With overlap check off, a remote Ux exit completes without looking for an LFPS overlap.
// - Every writable field is kept across a soft reset while reset protection is on.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module usb_link_config_register #(
  parameter int ADDR_W = 12,
  parameter int RESUME_BASE_CYC = usb_link_cfg_pkg::RESUME_BASE_CYC,
  parameter int RESUME_STEP_CYC = usb_link_cfg_pkg::RESUME_STEP_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Controller-side events, same clock
  input wire logic soft_reset,
  input wire logic wake_req,
  // Link and PHY inputs, asynchronous
  input wire logic lpm_req,
  input wire logic [3:0] host_hird,
  input wire logic l1_exit,
  input wire logic suspend_cond,
  input wire logic ux_exit_start,
  input wire logic remote_lfps,
  input wire logic ts_seen,
  // LPM and L1 outputs
  output logic lpm_ack_q,
  output logic lpm_stall_q,
  output logic in_l1_q,
  output logic phy_deep_lp_q,
  output logic utmi_sleep_q,
  output logic resume_drive_q,
  // PHY suspend, active low
  output logic phy_suspend_n_q,
  // Applied configuration and Ux exit handshake completion
  output logic [4:0] bulk_in_burst_pkts_q,
  output logic [4:0] bulk_out_burst_pkts_q,
  output logic [2:0] connect_speed_q,
  output logic lfps_overlap_check_q,
  output logic lfps_handshake_done_q
);

  localparam int SYNC_W = $bits(usb_link_cfg_pkg::link_in_t);

  // Register state
  usb_link_cfg_pkg::link_cfg_t cfg_q;
  usb_link_cfg_pkg::link_cfg_t cfg_d;
  logic protect_q;
  logic protect_d;

  // Bus channel state
  logic aw_held_q;
  logic w_held_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // Link state
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  usb_link_cfg_pkg::link_in_t lin;
  logic lpm_req_prev_q;
  logic [3:0] hird_q;
  logic deep_sel_q;
  logic resume_active;
  logic resume_done;
  logic hs_waiting;
  logic hs_done;

  // Two-flop synchronisers for every pin input
  wire [SYNC_W-1:0] sync_in = {lpm_req, host_hird, l1_exit, suspend_cond, ux_exit_start, remote_lfps, ts_seen};
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= sync_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate
  // HIRD bits are taken on the request edge; the host holds them stable well before it
  assign lin = usb_link_cfg_pkg::link_in_t'(sync2_q);

  // Write side: address and data may arrive in either order
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_go = aw_held_q && w_held_q && !bvalid_q;
  wire [ADDR_W-1:0] wr_word = {awaddr_q[ADDR_W-1:2], 2'b00};
  wire wr_cfg = wr_go && (wr_word == ADDR_W'(usb_link_cfg_pkg::CFG0_OFF));
  wire wr_stat = wr_go && (wr_word == ADDR_W'(usb_link_cfg_pkg::STATUS_OFF));
  wire wr_prot = wr_go && (wr_word == ADDR_W'(usb_link_cfg_pkg::PROTECT_OFF));
  wire wr_hit = wr_cfg || wr_stat || wr_prot;

  // Current register images
  wire [31:0] cfg_word = {1'b0, cfg_q, 12'h000};
  wire [31:0] stat_word = {24'h00_0000, hs_waiting, lin.suspend_cond, resume_active, deep_sel_q,
                           utmi_sleep_q, phy_deep_lp_q, in_l1_q, ~phy_suspend_n_q};
  wire [31:0] prot_word = {31'h0000_0000, protect_q};

  // Byte-lane merge of write data into the configuration word
  logic [31:0] cfg_merged;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign cfg_merged[gi*8 +: 8] = wstrb_q[gi] ? wdata_q[gi*8 +: 8] : cfg_word[gi*8 +: 8];
    end
  endgenerate

  // Next configuration: a write wins over a soft reset in the same cycle
  always_comb begin
    cfg_d = cfg_q;
    if (soft_reset && !protect_q) begin
      cfg_d = usb_link_cfg_pkg::CFG_RST;
    end
    if (wr_cfg) begin
      cfg_d = usb_link_cfg_pkg::link_cfg_t'(cfg_merged[usb_link_cfg_pkg::CFG_MSB:usb_link_cfg_pkg::CFG_LSB]);
    end
  end
  assign protect_d = (wr_prot && wstrb_q[0]) ? wdata_q[0] : protect_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= usb_link_cfg_pkg::CFG_RST;
      protect_q <= usb_link_cfg_pkg::PROTECT_RST;
    end else begin
      cfg_q <= cfg_d;
      protect_q <= protect_d;
    end
  end

  // Write address and data holding registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held_q <= 1'b0;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Write response; the status register is read-only and refuses writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= usb_link_cfg_pkg::RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= (wr_hit && !wr_stat) ? usb_link_cfg_pkg::RESP_OKAY : usb_link_cfg_pkg::RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready = !w_held_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // Read side: one read under way; answer one cycle after the address is taken
  wire ar_take = s_axi_arvalid && !rvalid_q;
  wire [ADDR_W-1:0] rd_word = {s_axi_araddr[ADDR_W-1:2], 2'b00};
  wire rd_cfg = (rd_word == ADDR_W'(usb_link_cfg_pkg::CFG0_OFF));
  wire rd_stat = (rd_word == ADDR_W'(usb_link_cfg_pkg::STATUS_OFF));
  wire rd_prot = (rd_word == ADDR_W'(usb_link_cfg_pkg::PROTECT_OFF));
  wire [31:0] rd_mux = rd_cfg ? cfg_word : rd_stat ? stat_word : rd_prot ? prot_word : 32'h0000_0000;
  wire rd_hit = rd_cfg || rd_stat || rd_prot;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= usb_link_cfg_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= rd_hit ? usb_link_cfg_pkg::RESP_OKAY : usb_link_cfg_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // LPM handshake and L1 entry
  wire lpm_edge = lin.lpm_req && !lpm_req_prev_q;
  wire lpm_accept = lpm_edge && cfg_q.link_power_mgmt_capability && !in_l1_q;
  wire lpm_refuse = lpm_edge && !lpm_accept;
  wire deep_pick = (lin.hird >= cfg_q.resume_duration_threshold[3:0])
                   && cfg_q.resume_duration_threshold[4];
  wire l1_leave = in_l1_q && (lin.l1_exit || resume_done);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lpm_req_prev_q <= 1'b0;
      lpm_ack_q <= 1'b0;
      lpm_stall_q <= 1'b0;
      in_l1_q <= 1'b0;
      hird_q <= 4'h0;
      deep_sel_q <= 1'b0;
    end else begin
      lpm_req_prev_q <= lin.lpm_req;
      lpm_ack_q <= lpm_accept;
      lpm_stall_q <= lpm_refuse;
      if (lpm_accept) begin
        in_l1_q <= 1'b1;
        hird_q <= lin.hird;
        deep_sel_q <= deep_pick;
      end else if (l1_leave) begin
        in_l1_q <= 1'b0;
      end
    end
  end

  // PHY power state in L1; resume signalling ends both modes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phy_deep_lp_q <= 1'b0;
      utmi_sleep_q <= 1'b0;
      phy_suspend_n_q <= 1'b1;
    end else begin
      phy_deep_lp_q <= in_l1_q && !l1_leave && !resume_active && deep_sel_q;
      utmi_sleep_q <= in_l1_q && !l1_leave && !resume_active && !deep_sel_q;
      phy_suspend_n_q <= !(cfg_q.suspend_allow && lin.suspend_cond);
    end
  end

  // Device-initiated resume from L1 lasts the time the threshold code selects
  resume_timer #(
    .BASE_CYC(RESUME_BASE_CYC),
    .STEP_CYC(RESUME_STEP_CYC)
  ) u_resume (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(wake_req && in_l1_q),
    .code(cfg_q.resume_duration_threshold[3:0]),
    .active_q(resume_active),
    .done_q(resume_done)
  );
  assign resume_drive_q = resume_active;

  // Ux exit handshake with optional LFPS overlap check
  ux_exit_handshake u_ux_exit (
    .aclk(aclk),
    .aresetn(aresetn),
    .check_en(cfg_q.lfps_overlap_check_enable),
    .exit_start(lin.ux_exit_start),
    .remote_lfps(lin.remote_lfps),
    .ts_seen(lin.ts_seen),
    .waiting_q(hs_waiting),
    .done_q(hs_done)
  );
  assign lfps_handshake_done_q = hs_done;

  // Applied configuration; burst fields hold packets minus one, values above 3 pass unchecked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bulk_in_burst_pkts_q <= 5'h01;
      bulk_out_burst_pkts_q <= 5'h01;
      connect_speed_q <= usb_link_cfg_pkg::CFG_RST.connect_speed_select;
      lfps_overlap_check_q <= usb_link_cfg_pkg::CFG_RST.lfps_overlap_check_enable;
    end else begin
      bulk_in_burst_pkts_q <= {1'b0, cfg_q.bulk_in_burst_limit} + 5'h01;
      bulk_out_burst_pkts_q <= {1'b0, cfg_q.bulk_out_burst_limit} + 5'h01;
      connect_speed_q <= cfg_q.connect_speed_select;
      lfps_overlap_check_q <= cfg_q.lfps_overlap_check_enable;
    end
  end

endmodule
`default_nettype wire

// [usb_link_cfg_sva.sv]
// Concurrent checks on the ports of the USB link configuration register
`timescale 1ns/1ps
`default_nettype none
module usb_link_cfg_sva #(
  parameter int RESUME_BASE_CYC = 1000,
  parameter int RESUME_STEP_CYC = 1500
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Link pins
  input wire logic suspend_cond,
  input wire logic remote_lfps,
  input wire logic ts_seen,
  // Outputs under check
  input wire logic lpm_ack_q,
  input wire logic lpm_stall_q,
  input wire logic in_l1_q,
  input wire logic phy_deep_lp_q,
  input wire logic utmi_sleep_q,
  input wire logic resume_drive_q,
  input wire logic phy_suspend_n_q,
  input wire logic [4:0] bulk_in_burst_pkts_q,
  input wire logic [4:0] bulk_out_burst_pkts_q,
  input wire logic [2:0] connect_speed_q,
  input wire logic lfps_overlap_check_q,
  input wire logic lfps_handshake_done_q
);
  // Longest resume is code 15; a stuck timer would run past it
  localparam int RES_MAX = RESUME_BASE_CYC + 15 * RESUME_STEP_CYC;
  logic [15:0] res_cnt_q;
  logic [15:0] res_cnt_d;
  assign res_cnt_d = resume_drive_q ? res_cnt_q + 16'h0001 : 16'h0000;
  always_ff @(posedge aclk) begin
    if (!aresetn) res_cnt_q <= 16'h0000;
    else res_cnt_q <= res_cnt_d;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_deep_sleep_excl: assert property (!(phy_deep_lp_q && utmi_sleep_q))
    else $error("deep low-power and sleep both on");
  chk_l1_mode_pick: assert property ($rose(in_l1_q) |=> phy_deep_lp_q ^ utmi_sleep_q)
    else $error("no low-power mode chosen after entering L1");
  chk_ack_enters_l1: assert property (lpm_ack_q |-> in_l1_q && !lpm_stall_q)
    else $error("accept without L1 or with refusal");
  chk_suspend_idle: assert property ((!suspend_cond) [*6] |-> phy_suspend_n_q)
    else $error("suspend asserted without suspend conditions");
  chk_reset_values: assert property ($rose(aresetn) |-> connect_speed_q == 3'h4 && bulk_in_burst_pkts_q == 5'h01)
    else $error("wrong applied values after reset");
  chk_in_burst_min: assert property (bulk_in_burst_pkts_q != 5'h00)
    else $error("bulk-in burst of zero packets");
  chk_out_burst_min: assert property (bulk_out_burst_pkts_q != 5'h00)
    else $error("bulk-out burst of zero packets");
  chk_overlap_wait: assert property ((lfps_overlap_check_q && !remote_lfps && !ts_seen) [*6] |-> !lfps_handshake_done_q)
    else $error("handshake done without remote LFPS or training symbols");
  chk_resume_bound: assert property (res_cnt_q <= RES_MAX)
    else $error("resume signalling too long");
  chk_rsvd_zero: assert property (s_axi_rvalid |-> !s_axi_rdata[31])
    else $error("reserved bit reads one");
  chk_b_hold: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
    else $error("write response withdrawn early");
  chk_r_hold: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
    else $error("read data withdrawn early");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
endmodule
bind usb_link_config_register usb_link_cfg_sva #(
  .RESUME_BASE_CYC(RESUME_BASE_CYC),
  .RESUME_STEP_CYC(RESUME_STEP_CYC)
) usb_link_cfg_sva_inst (.*);
`default_nettype wire

// [usb_host_model.sv]
// Behavioural host and PHY event source facing the link pins
`timescale 1ns/1ps
`default_nettype none
module usb_host_model (
  // Clock
  input wire logic aclk,
  // Link and PHY pins
  output logic lpm_req,
  output logic [3:0] host_hird,
  output logic l1_exit,
  output logic suspend_cond,
  output logic ux_exit_start,
  output logic remote_lfps,
  output logic ts_seen
);
  initial {lpm_req, host_hird, l1_exit, suspend_cond, ux_exit_start, remote_lfps, ts_seen} = '0;
  // HIRD settles a cycle before the request and is scrambled once released
  task automatic lpm(input logic [3:0] h);
    @(posedge aclk);
    host_hird <= h;
    @(posedge aclk);
    lpm_req <= 1'b1;
    repeat (6) @(posedge aclk);
    lpm_req <= 1'b0;
    host_hird <= ~h;
  endtask
  task automatic end_l1();
    @(posedge aclk);
    l1_exit <= 1'b1;
    repeat (6) @(posedge aclk);
    l1_exit <= 1'b0;
  endtask
  task automatic ux_exit();
    @(posedge aclk);
    ux_exit_start <= 1'b1;
    @(posedge aclk);
    ux_exit_start <= 1'b0;
  endtask
  task automatic answer(input logic use_ts);
    @(posedge aclk);
    if (use_ts) ts_seen <= 1'b1;
    else remote_lfps <= 1'b1;
    repeat (4) @(posedge aclk);
    ts_seen <= 1'b0;
    remote_lfps <= 1'b0;
  endtask
  task automatic set_susp(input logic v);
    @(posedge aclk);
    suspend_cond <= v;
  endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the USB link configuration register
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic aclk = 1'b0;
  logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, soft_reset, wake_req;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, host_hird, hird;
  logic [4:0] thr;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic lpm_req, l1_exit, suspend_cond, ux_exit_start, remote_lfps, ts_seen;
  logic lpm_ack_q, lpm_stall_q, in_l1_q, phy_deep_lp_q, utmi_sleep_q, resume_drive_q, phy_suspend_n_q;
  logic [4:0] bulk_in_burst_pkts_q, bulk_out_burst_pkts_q;
  logic [2:0] connect_speed_q;
  logic lfps_overlap_check_q, lfps_handshake_done_q;
  logic [8:0] lp_tab [4] = '{9'h157, 9'h153, 9'h059, 9'h155};
  int n_fail = 0, comparisons = 0, n_ack = 0, n_stall = 0, n_done = 0, seed = 55244, k, n;
  always #25 aclk = ~aclk;
  usb_link_config_register #(.RESUME_BASE_CYC(10), .RESUME_STEP_CYC(15)) usb_link_config_register_inst (.*);
  usb_host_model usb_host_model_inst (.*);
  // Pulses are tallied so a scenario can look after they are gone
  always @(posedge aclk) begin
    if (lpm_ack_q === 1'b1) n_ack <= n_ack + 1;
    if (lpm_stall_q === 1'b1) n_stall <= n_stall + 1;
    if (lfps_handshake_done_q === 1'b1) n_done <= n_done + 1;
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_up();
    n_fail++;
    $display("mismatch at %0t: timeout got %h expected %h", $time, 1'b0, 1'b1);
    stop_test();
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] wd, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        cmp(32'(s_axi_bresp), 32'(er));
        s_axi_bready <= 1'b0;
        return;
      end
    end
    give_up();
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 40; i++) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        cmp(s_axi_rdata, ed);
        cmp(32'(s_axi_rresp), 32'(er));
        s_axi_rready <= 1'b0;
        return;
      end
    end
    give_up();
  endtask
  task automatic wcfg(input logic [31:0] wd);
    wr(usb_link_cfg_pkg::CFG0_OFF, wd, usb_link_cfg_pkg::RESP_OKAY);
  endtask
  task automatic rcfg(input logic [31:0] ed);
    rd(usb_link_cfg_pkg::CFG0_OFF, ed, usb_link_cfg_pkg::RESP_OKAY);
  endtask
  task automatic pulse_soft_reset();
    @(posedge aclk);
    soft_reset <= 1'b1;
    @(posedge aclk);
    soft_reset <= 1'b0;
  endtask
  function automatic logic [31:0] cfg_word(input logic cap, input logic sus, input logic [4:0] t, input logic ovl);
    return {1'b0, cap, sus, t, 8'h00, usb_link_cfg_pkg::SPD_SUPER, ovl, 12'h000};
  endfunction
  function automatic logic exp_deep(input logic [4:0] t, input logic [3:0] h);
    return t[4] && (h >= t[3:0]);
  endfunction
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, soft_reset, wake_req} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    // Two edges; the pin synchronisers clear under the same reset
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rcfg(32'h2000_8000);
    for (int i = 0; i < 9; i++) begin
      d = $random(seed);
      d[23:22] = 2'b00;
      d[19:18] = 2'b00;
      d[15:13] = (i % 3 == 0) ? usb_link_cfg_pkg::SPD_SUPER : (i % 3 == 1) ? 3'h0 : 3'h1;
      wcfg(d);
      rcfg(d & 32'h7FFF_F000);
      cmp(32'(bulk_in_burst_pkts_q), 32'(d[23:20]) + 1);
      cmp(32'(bulk_out_burst_pkts_q), 32'(d[19:16]) + 1);
      cmp(32'(connect_speed_q), 32'(d[15:13]));
      cmp(32'(lfps_overlap_check_q), 32'(d[12]));
    end
    // Only lane 2 may land: the burst fields change, the rest keeps its value
    s_axi_wstrb <= 4'h4;
    wcfg(32'hFFFF_FFFF);
    s_axi_wstrb <= 4'hF;
    rcfg({1'b0, d[30:24], 8'hFF, d[15:12], 12'h000});
    wr(12'h0C0, d, usb_link_cfg_pkg::RESP_SLVERR);
    wr(usb_link_cfg_pkg::STATUS_OFF, d, usb_link_cfg_pkg::RESP_SLVERR);
    rd(12'h0C0, 32'h0000_0000, usb_link_cfg_pkg::RESP_SLVERR);
    $display("test register access done");
    wcfg(cfg_word(1'b1, 1'b0, 5'h15, 1'b1));
    wr(usb_link_cfg_pkg::PROTECT_OFF, 32'h0000_0001, usb_link_cfg_pkg::RESP_OKAY);
    rd(usb_link_cfg_pkg::PROTECT_OFF, 32'h0000_0001, usb_link_cfg_pkg::RESP_OKAY);
    pulse_soft_reset();
    rcfg(cfg_word(1'b1, 1'b0, 5'h15, 1'b1));
    wr(usb_link_cfg_pkg::PROTECT_OFF, 32'h0000_0000, usb_link_cfg_pkg::RESP_OKAY);
    pulse_soft_reset();
    rcfg(32'h2000_8000);
    rd(usb_link_cfg_pkg::STATUS_OFF, 32'h0000_0000, usb_link_cfg_pkg::RESP_OKAY);
    $display("test reset protection done");
    wcfg(cfg_word(1'b0, 1'b0, 5'h15, 1'b0));
    k = n_stall;
    usb_host_model_inst.lpm(4'h9);
    cmp(n_stall - k, 1);
    cmp(32'(in_l1_q), 32'h0);
    for (int i = 0; i < 8; i++) begin
      {thr, hird} = (i < 4) ? lp_tab[i] : 9'($random(seed));
      wcfg(cfg_word(1'b1, 1'b0, thr, 1'b0));
      k = n_ack;
      usb_host_model_inst.lpm(hird);
      cmp(n_ack - k, 1);
      cmp(32'(phy_deep_lp_q), 32'(exp_deep(thr, hird)));
      cmp(32'(utmi_sleep_q), 32'(!exp_deep(thr, hird)));
      usb_host_model_inst.end_l1();
      repeat (6) @(posedge aclk);
      cmp(32'(in_l1_q), 32'h0);
    end
    wcfg(cfg_word(1'b1, 1'b0, 5'h15, 1'b0));
    usb_host_model_inst.lpm(4'h7);
    @(posedge aclk);
    wake_req <= 1'b1;
    @(posedge aclk);
    wake_req <= 1'b0;
    for (int i = 0; i < 10 && resume_drive_q !== 1'b1; i++) @(posedge aclk);
    n = 0;
    while (n < 400 && resume_drive_q === 1'b1) begin
      n++;
      @(posedge aclk);
    end
    cmp(n, 10 + 15 * 5);
    repeat (4) @(posedge aclk);
    cmp(32'(in_l1_q), 32'h0);
    $display("test link power done");
    usb_host_model_inst.set_susp(1'b1);
    repeat (8) @(posedge aclk);
    cmp(32'(phy_suspend_n_q), 32'h1);
    wcfg(cfg_word(1'b0, 1'b1, 5'h00, 1'b0));
    repeat (8) @(posedge aclk);
    cmp(32'(phy_suspend_n_q), 32'h0);
    usb_host_model_inst.set_susp(1'b0);
    repeat (8) @(posedge aclk);
    cmp(32'(phy_suspend_n_q), 32'h1);
    k = n_done;
    usb_host_model_inst.ux_exit();
    repeat (6) @(posedge aclk);
    cmp(n_done - k, 1);
    wcfg(cfg_word(1'b0, 1'b1, 5'h00, 1'b1));
    for (int j = 0; j < 2; j++) begin
      k = n_done;
      usb_host_model_inst.ux_exit();
      repeat (10) @(posedge aclk);
      cmp(n_done - k, 0);
      usb_host_model_inst.answer(j[0]);
      repeat (4) @(posedge aclk);
      cmp(n_done - k, 1);
    end
    $display("test suspend and exit done");
    stop_test();
  end
  initial begin
    repeat (100000) @(posedge aclk);
    give_up();
  end
endmodule
`default_nettype wire
